/* shared/flags_pkg.sv */
// Package for the processor status flag block.
// Assumes a single core clock domain and a plain register port.
package flags_pkg;

	localparam logic [7:0] FLAGS_OFFSET   = 8'h00;
	localparam logic [7:0] IRQ_STAT_OFF   = 8'h01;
	localparam logic [7:0] IRQ_MASK_OFF   = 8'h02;

	localparam int CARRY_BIT     = 0;
	localparam int HALF_BIT      = 1;
	localparam int ZERO_BIT      = 2;
	localparam int WRAP_BIT      = 3;
	localparam int SLEEP_BIT     = 4;
	localparam int WDOG_BIT      = 5;
	localparam int CHAIN_BIT     = 6;
	localparam int SLESS_BIT     = 7;

	localparam logic [7:0] SW_WRITE_MASK  = 8'hcf;
	localparam logic [7:0] FLAGS_RESET    = 8'h00;
	localparam logic [2:0] IRQ_RESET      = 3'h0;
	localparam logic [7:0] RESULT_RESET   = 8'h00;
	localparam logic [7:0] RDATA_RESET    = 8'h00;

	localparam int IRQ_WDOG      = 0;
	localparam int IRQ_SLEEP     = 1;
	localparam int IRQ_WRITE     = 2;

	typedef enum logic [3:0] {
		OP_NONE  = 4'h0,
		OP_ADD   = 4'h1,
		OP_ADC   = 4'h2,
		OP_SUB   = 4'h3,
		OP_SBC   = 4'h4,
		OP_LOGIC = 4'h5,
		OP_RLC   = 4'h6,
		OP_RRC   = 4'h7,
		OP_ROT   = 4'h8
	} alu_op_t;

endpackage : flags_pkg

/* hdl/flag_arith.sv */
// Combinational flag evaluation for one ALU operation.
// Assumes operands are valid in the cycle the operation is presented.
`timescale 1ns/1ps
`default_nettype none
module flag_arith
(
	input  wire flags_pkg::alu_op_t op,
	input  wire logic [7:0]         opa,
	input  wire logic [7:0]         opb,
	input  wire logic               carry_in,
	output logic [7:0]              result,
	output logic                    carry,
	output logic                    half,
	output logic                    wrap,
	output logic                    zero
);
	import flags_pkg::*;

	logic [8:0] sum;
	logic [4:0] lo;
	logic [7:0] lo7;
	logic [7:0] addend;
	logic       cin;
	logic       c7;

	always_comb begin
		addend = opb;
		cin    = 1'b0;
		case (op)
			OP_ADD: begin
				addend = opb;
				cin    = 1'b0;
			end
			OP_ADC: begin
				addend = opb;
				cin    = carry_in;
			end
			// Subtraction adds the complement, so carry out means no borrow.
			OP_SUB: begin
				addend = ~opb;
				cin    = 1'b1;
			end
			OP_SBC: begin
				addend = ~opb;
				cin    = carry_in;
			end
			default: begin
				addend = opb;
				cin    = 1'b0;
			end
		endcase
		sum    = {1'b0, opa} + {1'b0, addend} + {8'h00, cin};
		lo     = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		lo7    = {1'b0, opa[6:0]} + {1'b0, addend[6:0]} + {7'h00, cin};
		c7     = lo7[7];
		result = sum[7:0];
		carry  = sum[8];
		half   = lo[4];
		wrap   = c7 ^ sum[8];
		case (op)
			OP_LOGIC: begin
				result = opa;
				carry  = carry_in;
				half   = 1'b0;
				wrap   = 1'b0;
			end
			OP_RLC: begin
				result = {opa[6:0], carry_in};
				carry  = opa[7];
				half   = 1'b0;
				wrap   = 1'b0;
			end
			OP_RRC: begin
				result = {carry_in, opa[7:1]};
				carry  = opa[0];
				half   = 1'b0;
				wrap   = 1'b0;
			end
			OP_ROT: begin
				result = opa;
				carry  = carry_in;
				half   = 1'b0;
				wrap   = 1'b0;
			end
			default: begin
				result = sum[7:0];
			end
		endcase
		zero = (result == 8'h00);
	end

endmodule : flag_arith
`default_nettype wire

/* hdl/status_flags.sv */
//
// Contract
// - Carry set on add carry-out or subtract without borrow, else cleared.
// - Rotate through carry loads the shifted-out bit into carry.
// - Half carry set on low-nibble carry, or no nibble borrow on subtract.
// - Zero flag set on an all-zero arithmetic or logical result.
// - Signed wrap set when carry into MSB differs from carry out.
// - Signed less flag is new wrap XOR result MSB.
// - Plain subtract copies the new zero flag into chained zero.
// - Subtract with borrow ANDs chained zero with the new zero.
// - Chained zero unchanged by all other instructions.
// - Software writes never touch watchdog-expired or sleep-entered flags.
// - Watchdog time-out sets the watchdog-expired flag.
// - Power-up, watchdog clear or sleep clears watchdog-expired flag.
// - Power-up or watchdog clear also clears the sleep-entered flag.
// - Sleep instruction sets the sleep-entered flag.
// - No automatic save of flags on interrupt entry or call.
//
// Processor status flag register with event interrupt.
// Assumes the core presents one operation per cycle on alu_valid.
`timescale 1ns/1ps
`default_nettype none
module status_flags
(
	input  wire logic               core_clk,
	input  wire logic               nrst,
	input  wire logic               alu_valid,
	input  wire flags_pkg::alu_op_t alu_op,
	input  wire logic [7:0]         alu_a,
	input  wire logic [7:0]         alu_b,
	input  wire logic               watchdog_timeout,
	input  wire logic               watchdog_clear_instr,
	input  wire logic               sleep_instr,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [7:0]              reg_rdata,
	output logic [7:0]              alu_result,
	output logic [7:0]              flags_out,
	output logic                    irq
);
	import flags_pkg::*;

	////////////////////////////////////////////////////////////////////////

	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] result_r;
	logic [7:0] result_nxt;
	logic [2:0] stat_r;
	logic [2:0] stat_nxt;
	logic [2:0] mask_r;
	logic [2:0] mask_nxt;
	logic       irq_r;
	logic       irq_nxt;

	logic [7:0] res;
	logic       c_new;
	logic       h_new;
	logic       v_new;
	logic       z_new;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	flag_arith u_arith (
		.op       (alu_op),
		.opa      (alu_a),
		.opb      (alu_b),
		.carry_in (flags_r[CARRY_BIT]),
		.result   (res),
		.carry    (c_new),
		.half     (h_new),
		.wrap     (v_new),
		.zero     (z_new)
	);

	////////////////////////////////////////////////////////////////////////

	// Nothing here pushes the flags anywhere on interrupt or call.
	always_comb begin
		flags_nxt  = flags_r;
		result_nxt = result_r;
		if (reg_wr && hit(reg_addr, FLAGS_OFFSET)) begin
			flags_nxt = (reg_wdata & SW_WRITE_MASK)
				| (flags_r & ~SW_WRITE_MASK);
		end
		if (alu_valid) begin
			result_nxt = res;
			case (alu_op)
				OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
					flags_nxt[CARRY_BIT] = c_new;
					flags_nxt[HALF_BIT]  = h_new;
					flags_nxt[ZERO_BIT]  = z_new;
					flags_nxt[WRAP_BIT]  = v_new;
					flags_nxt[SLESS_BIT] = v_new ^ res[7];
				end
				OP_LOGIC: begin
					flags_nxt[ZERO_BIT] = z_new;
				end
				OP_RLC, OP_RRC: begin
					flags_nxt[CARRY_BIT] = c_new;
				end
				default: begin
					flags_nxt[ZERO_BIT] = flags_nxt[ZERO_BIT];
				end
			endcase
			case (alu_op)
				OP_SUB: flags_nxt[CHAIN_BIT] = z_new;
				OP_SBC: flags_nxt[CHAIN_BIT] = flags_r[CHAIN_BIT] & z_new;
				default: flags_nxt[CHAIN_BIT] = flags_nxt[CHAIN_BIT];
			endcase
		end
		// Watchdog clear beats both sleep and time-out in the same cycle.
		if (watchdog_clear_instr) begin
			flags_nxt[WDOG_BIT]  = 1'b0;
			flags_nxt[SLEEP_BIT] = 1'b0;
		end else begin
			if (sleep_instr) begin
				flags_nxt[SLEEP_BIT] = 1'b1;
				flags_nxt[WDOG_BIT]  = 1'b0;
			end
			if (watchdog_timeout) begin
				flags_nxt[WDOG_BIT] = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			flags_r  <= FLAGS_RESET;
			result_r <= RESULT_RESET;
		end else begin
			flags_r  <= flags_nxt;
			result_r <= result_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////

	// Event status bits are sticky; a new event wins over a clear.
	always_comb begin
		stat_nxt = stat_r;
		mask_nxt = mask_r;
		if (reg_wr && hit(reg_addr, IRQ_STAT_OFF)) begin
			stat_nxt = stat_r & ~reg_wdata[2:0];
		end
		if (reg_wr && hit(reg_addr, IRQ_MASK_OFF)) begin
			mask_nxt = reg_wdata[2:0];
		end
		if (watchdog_timeout) begin
			stat_nxt[IRQ_WDOG] = 1'b1;
		end
		if (sleep_instr) begin
			stat_nxt[IRQ_SLEEP] = 1'b1;
		end
		if (reg_wr && hit(reg_addr, FLAGS_OFFSET)
			&& ((reg_wdata ^ flags_r) & ~SW_WRITE_MASK) != 8'h00) begin
			stat_nxt[IRQ_WRITE] = 1'b1;
		end
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stat_r <= IRQ_RESET;
			mask_r <= IRQ_RESET;
			irq_r  <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r  <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			if (hit(reg_addr, FLAGS_OFFSET)) begin
				rdata_nxt = flags_r;
			end else if (hit(reg_addr, IRQ_STAT_OFF)) begin
				rdata_nxt = {5'h00, stat_r};
			end else if (hit(reg_addr, IRQ_MASK_OFF)) begin
				rdata_nxt = {5'h00, mask_r};
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rdata_r <= RDATA_RESET;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata  = rdata_r;
	assign alu_result = result_r;
	assign flags_out  = flags_r;
	assign irq        = irq_r;

endmodule : status_flags
`default_nettype wire

/* tb/flags_checker.sv */
// Port assertions for the status flag block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module flags_checker
(
	input wire logic               core_clk,
	input wire logic               nrst,
	input wire logic               alu_valid,
	input wire flags_pkg::alu_op_t alu_op,
	input wire logic               watchdog_timeout,
	input wire logic               watchdog_clear_instr,
	input wire logic               sleep_instr,
	input wire logic               reg_wr,
	input wire logic [7:0]         alu_result,
	input wire logic [7:0]         flags_out
);
	import flags_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	wire logic [7:0] f   = flags_out;
	wire logic       wto = watchdog_timeout;
	wire logic       cl  = watchdog_clear_instr;
	wire logic       sl  = sleep_instr;
	wire logic       sub = alu_valid && alu_op == OP_SUB;
	wire logic       sbc = alu_valid && alu_op == OP_SBC;
	wire logic       ar  = sub || sbc || alu_valid && alu_op inside {OP_ADD, OP_ADC};
	property p_wd_set; wto && !cl |=> f[5]; endproperty
	a_wd_set: assert property (p_wd_set) else $error("bit5 not set");
	property p_wd_clr; cl || sl && !wto |=> !f[5]; endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("bit5 kept");
	property p_sl_clr; cl |=> !f[4]; endproperty
	a_sl_clr: assert property (p_sl_clr) else $error("bit4 kept");
	property p_sl_set; sl && !cl |=> f[4]; endproperty
	a_sl_set: assert property (p_sl_set) else $error("bit4 not set");
	property p_sub; sub |=> f[6] == f[2]; endproperty
	a_sub: assert property (p_sub) else $error("bit6 not zero copy");
	property p_sbc; sbc |=> f[6] == ($past(f[6]) & f[2]); endproperty
	a_sbc: assert property (p_sbc) else $error("bit6 not chained");
	property p_keep; alu_valid && !sub && !sbc && !reg_wr |=> $stable(f[6]); endproperty
	a_keep: assert property (p_keep) else $error("bit6 changed");
	property p_sc; ar |=> f[7] == (f[3] ^ alu_result[7]); endproperty
	a_sc: assert property (p_sc) else $error("bit7 wrong");
	c_sbc: cover property (sbc ##1 f[6]);
	c_wd: cover property (wto ##1 f[5]);
	c_wr: cover property (reg_wr ##1 f[4]);
endmodule : flags_checker
`default_nettype wire

/* tb/core_model.sv */
// Model of the core issuing ALU operations and system events.
// Assumes one caller at a time; operands are inverted while idle.
`timescale 1ns/1ps
`default_nettype none
module core_model
(
	input  wire logic               core_clk,
	output var logic                alu_valid,
	output var flags_pkg::alu_op_t  alu_op,
	output var logic [7:0]          alu_a,
	output var logic [7:0]          alu_b,
	output var logic [2:0]          ev
);
	import flags_pkg::*;
	initial begin
		alu_valid = 1'b0;
		alu_op = OP_NONE;
		alu_a = 8'h00;
		alu_b = 8'h00;
		ev = 3'h0;
	end
	// Event bits are timeout, watchdog clear, sleep.
	task automatic go(input logic [2:0] e, input alu_op_t o,
		input logic [7:0] a, input logic [7:0] b);
		@(posedge core_clk);
		alu_valid <= o != OP_NONE;
		alu_op <= o;
		alu_a <= a;
		alu_b <= b;
		ev <= e;
		@(posedge core_clk);
		alu_valid <= 1'b0;
		alu_a <= ~a;
		alu_b <= ~b;
		ev <= 3'h0;
	endtask : go
endmodule : core_model
`default_nettype wire

/* tb/status_flags_test.sv */
// Self-checking bench for the status flag block.
// Assumes the core model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module status_flags_test;
	import flags_pkg::*;
	logic             core_clk  = 1'b0;
	logic             nrst      = 1'b0;
	logic             reg_wr    = 1'b0;
	logic             reg_rd    = 1'b0;
	logic [7:0]       reg_addr  = 8'h00;
	logic [7:0]       reg_wdata = 8'h00;
	logic [7:0]       reg_rdata, alu_result, flags_out, alu_a, alu_b;
	logic             irq, alu_valid;
	logic [2:0]       ev;
	alu_op_t          alu_op;
	int               fails = 0, n_tests = 0, cyc = 0;
	// Each row: op, a, b, expected result, expected flags.
	logic [35:0]      t [12] = '{36'h1ff010007, 36'h17f01800a, 36'h305050047,
		36'h400000047, 36'h403010203, 36'h30001ff80, 36'h380017f89,
		36'h50000008d, 36'h70000808c, 36'h68000008d, 36'h20f001002,
		36'h800ff0002};
	always #25 core_clk = ~core_clk;
	core_model u_core (.core_clk(core_clk), .alu_valid(alu_valid),
		.alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .ev(ev));
	status_flags dut (.core_clk(core_clk), .nrst(nrst), .alu_valid(alu_valid),
		.alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .irq(irq),
		.watchdog_timeout(ev[2]), .watchdog_clear_instr(ev[1]),
		.sleep_instr(ev[0]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.alu_result(alu_result), .flags_out(flags_out));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask : rdc
	task automatic ev_chk(input logic [2:0] e, input logic [7:0] x);
		u_core.go(e, OP_NONE, 8'h00, 8'h00);
		#1 `CHK(flags_out, x)
	endtask : ev_chk
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		rdc(FLAGS_OFFSET, 8'h00);
		for (int i = 0; i < 12; i++) begin
			u_core.go(3'h0, alu_op_t'(t[i][35:32]), t[i][31:24], t[i][23:16]);
			#1 `CHK(alu_result, t[i][15:8])
			`CHK(flags_out, t[i][7:0])
		end
		wr(FLAGS_OFFSET, 8'hff);
		rdc(FLAGS_OFFSET, 8'hcf);
		rdc(IRQ_STAT_OFF, 8'h04);
		`CHK(irq, 1'b0)
		wr(IRQ_MASK_OFF, 8'h01);
		ev_chk(3'h4, 8'hef);
		@(posedge core_clk);
		#1 `CHK(irq, 1'b1)
		ev_chk(3'h1, 8'hdf);
		wr(IRQ_STAT_OFF, 8'h07);
		@(posedge core_clk);
		#1 `CHK(irq, 1'b0)
		wr(FLAGS_OFFSET, 8'h00);
		rdc(FLAGS_OFFSET, 8'h10);
		ev_chk(3'h5, 8'h30);
		ev_chk(3'h7, 8'h00);
		ev_chk(3'h5, 8'h30);
		// A second power-up must clear both event flags once they are set.
		@(posedge core_clk);
		nrst <= 1'b0;
		@(posedge core_clk);
		nrst <= 1'b1;
		rdc(FLAGS_OFFSET, 8'h00);
		rdc(8'h03, 8'h00);
		end_of_test();
	end
endmodule : status_flags_test
bind status_flags flags_checker u_chk (.core_clk(core_clk), .nrst(nrst),
	.alu_valid(alu_valid), .alu_op(alu_op), .reg_wr(reg_wr),
	.watchdog_timeout(watchdog_timeout), .sleep_instr(sleep_instr),
	.watchdog_clear_instr(watchdog_clear_instr),
	.alu_result(alu_result), .flags_out(flags_out));
`default_nettype wire
